// ---- common/mcu_intv_defs.vh ----
`ifndef MCU_INTV_DEFS_VH
`define MCU_INTV_DEFS_VH

`define ADDR_W 13
`define DATA_W 8

`define OFF_SYNC_CTRL 13'h000A
`define OFF_SYNC_FLAGS 13'h000B
`define OFF_ASYNC_CTRL2 13'h000F
`define OFF_ASYNC_FLAGS 13'h0010
`define OFF_TIMER_CTRL 13'h0012
`define OFF_TIMER_FLAGS 13'h0013
`define OFF_PIN_OPTION 13'h1FDF
`define OFF_INT_STATUS 13'h1FE0
`define OFF_INT_ENABLE 13'h1FE1
`define OFF_INT_CLEAR 13'h1FE2

`define VEC_RESET 13'h1FFE
`define VEC_TRAP 13'h1FFC
`define VEC_EXT 13'h1FFA
`define VEC_TIMER 13'h1FF8
`define VEC_ASYNC 13'h1FF6
`define VEC_SYNC 13'h1FF4

`define REG_RESET 8'h00
`define OPT_RESET 8'h00
`define OPT_EDGE_ONLY_BIT 1
`define CC_MASK_BIT 3

`define TMR_EN_HI 7
`define TMR_EN_LO 5
`define ASY_TIE_BIT 7
`define ASY_TCIE_BIT 6
`define ASY_RIE_BIT 5
`define ASY_ILIE_BIT 4
`define SYN_EN_BIT 7
`define SYN_DONE_BIT 7
`define SYN_FAULT_BIT 4

`define SRC_TRAP 0
`define SRC_EXT 1
`define SRC_TIMER 2
`define SRC_ASYNC 3
`define SRC_SYNC 4
`define SRC_W 5

`define STK_PCL 3'h0
`define STK_PCH 3'h1
`define STK_X 3'h2
`define STK_A 3'h3
`define STK_CC 3'h4

`endif

// ---- hw/mcu_interrupt_vectoring.v ----
// Operation
// - Five sources: external pin, timer, sync serial, async serial, unmaskable software trap.
// - A cleared enable blocks the request but its flag still sets.
// - Reset clears all peripheral interrupt enables.
// - Flag clears after status access with flag set, then associated register access.
// - Pending enabled request is taken only at an instruction boundary.
// - Entry pushes pc low, pc high, index, accumulator, condition codes; sets mask.
// - Return pulls the five bytes in reverse order then resumes.
// - Return leaves mask cleared exactly when the restored mask bit is zero.
// - Reset sets mask and loads the program counter from the reset vector.
// - Software trap enters regardless of mask, using the vector below reset.
// - External interrupt taken when mask clear and pin low; own vector.
// - Option bit selects edge-only or edge-and-level pin sensitivity.
// - Three timer flags in top status bits, own enables, one shared vector.
// - Peripheral request reaches the CPU only with flag, enable and mask clear.
// - Async serial merges five flags onto one vector; software reads status for cause.
// - Sync serial requests on transfer-done or mode-fault through one vector.
// - Flags live in read-only status registers, enables in separate control registers.
`include "mcu_intv_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module mcu_interrupt_vectoring #(
	parameter ADDR_W = `ADDR_W,
	parameter DATA_W = `DATA_W
) (
	input wire core_clk,
	input wire rst_n,
	input wire clk_en,
	input wire [ADDR_W-1:0] reg_addr,
	input wire [DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [DATA_W-1:0] reg_rdata,
	input wire irq_pin_n,
	input wire capture_evt,
	input wire compare_evt,
	input wire overflow_evt,
	input wire tx_empty_evt,
	input wire tx_done_evt,
	input wire rx_full_evt,
	input wire idle_evt,
	input wire overrun_evt,
	input wire sync_done_evt,
	input wire sync_fault_evt,
	input wire instr_boundary,
	input wire trap_exec,
	input wire rti_exec,
	input wire mask_set,
	input wire mask_clr,
	input wire [ADDR_W-1:0] pc_in,
	input wire [DATA_W-1:0] x_in,
	input wire [DATA_W-1:0] a_in,
	input wire [DATA_W-1:0] cc_in,
	input wire [DATA_W-1:0] pull_data,
	output reg cpu_hold,
	output reg mask_bit,
	output reg stack_push,
	output reg [DATA_W-1:0] stack_data,
	output reg stack_pull,
	output reg [2:0] pull_sel,
	output reg restore_valid,
	output reg [2:0] restore_sel,
	output reg [DATA_W-1:0] restore_data,
	output reg vector_load,
	output reg [ADDR_W-1:0] vector_addr,
	output reg int_out
);

	localparam [4:0] ST_RESET = 5'h01;
	localparam [4:0] ST_IDLE = 5'h02;
	localparam [4:0] ST_PUSH = 5'h04;
	localparam [4:0] ST_VEC = 5'h08;
	localparam [4:0] ST_PULL = 5'h10;

	function hit;
		input [ADDR_W-1:0] a;
		input [ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	function [7:0] flag_next;
		input [7:0] flags;
		input [7:0] arm;
		input clr_en;
		input [7:0] evt;
		begin
			flag_next = (flags & ~(clr_en ? arm : 8'h00)) | evt;
		end
	endfunction

	reg rst_s1_q;
	reg rst_s2_q;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire srst_n = rst_s2_q;

	reg [DATA_W-1:0] tmr_ctrl_q;
	reg [DATA_W-1:0] asy_ctrl_q;
	reg [DATA_W-1:0] syn_ctrl_q;
	reg [DATA_W-1:0] opt_q;
	reg [2:0] tmr_flags_q;
	reg [4:0] asy_flags_q;
	reg [1:0] syn_flags_q;
	reg [2:0] tmr_arm_q;
	reg [4:0] asy_arm_q;
	reg [1:0] syn_arm_q;
	reg [`SRC_W-1:0] int_status_q;
	reg [`SRC_W-1:0] int_en_q;
	reg irq_prev_q;
	reg irq_latch_q;
	reg [4:0] state_q;
	reg [2:0] idx_q;
	reg [ADDR_W-1:0] vec_q;
	reg pull_pend_q;
	reg [2:0] pull_sel_q;

	wire acc_tmr_ctrl = (reg_rd | reg_wr) & hit(reg_addr, `OFF_TIMER_CTRL);
	wire acc_asy_ctrl = (reg_rd | reg_wr) & hit(reg_addr, `OFF_ASYNC_CTRL2);
	wire acc_syn_ctrl = (reg_rd | reg_wr) & hit(reg_addr, `OFF_SYNC_CTRL);
	wire rd_tmr_stat = reg_rd & hit(reg_addr, `OFF_TIMER_FLAGS);
	wire rd_asy_stat = reg_rd & hit(reg_addr, `OFF_ASYNC_FLAGS);
	wire rd_syn_stat = reg_rd & hit(reg_addr, `OFF_SYNC_FLAGS);

	wire [DATA_W-1:0] tmr_stat_v = {tmr_flags_q, 5'h00};
	wire [DATA_W-1:0] asy_stat_v = {asy_flags_q, 3'h0};
	wire [DATA_W-1:0] syn_stat_v = {syn_flags_q[1], 2'h0, syn_flags_q[0], 4'h0};
	wire [7:0] tmr_fn = flag_next({5'h00, tmr_flags_q}, {5'h00, tmr_arm_q}, acc_tmr_ctrl,
		{5'h00, capture_evt, compare_evt, overflow_evt});
	wire [7:0] asy_fn = flag_next({3'h0, asy_flags_q}, {3'h0, asy_arm_q}, acc_asy_ctrl,
		{3'h0, tx_empty_evt, tx_done_evt, rx_full_evt, idle_evt, overrun_evt});
	wire [7:0] syn_fn = flag_next({6'h00, syn_flags_q}, {6'h00, syn_arm_q}, acc_syn_ctrl,
		{6'h00, sync_done_evt, sync_fault_evt});

	wire [4:0] asy_en = {asy_ctrl_q[`ASY_TIE_BIT], asy_ctrl_q[`ASY_TCIE_BIT],
		asy_ctrl_q[`ASY_RIE_BIT], asy_ctrl_q[`ASY_ILIE_BIT], asy_ctrl_q[`ASY_RIE_BIT]};

	// Peripheral requests gated by flag and enable; mask applied at the boundary
	wire tmr_req = |(tmr_flags_q & tmr_ctrl_q[`TMR_EN_HI:`TMR_EN_LO]);
	wire asy_req = |(asy_flags_q & asy_en);
	wire syn_req = |syn_flags_q & syn_ctrl_q[`SYN_EN_BIT];
	wire ext_req = irq_latch_q | (~opt_q[`OPT_EDGE_ONLY_BIT] & ~irq_pin_n);
	wire any_req = ext_req | tmr_req | asy_req | syn_req;
	wire take_mask = instr_boundary & ~mask_bit & any_req;
	wire take_trap = trap_exec;
	wire take_rti = rti_exec & ~trap_exec;
	wire idle = state_q[1];
	wire start_entry = idle & (take_trap | (take_mask & ~take_rti));
	wire ext_taken = idle & ~take_trap & ~take_rti & take_mask & ext_req;

	reg [`SRC_W-1:0] entry_src;
	reg [ADDR_W-1:0] entry_vec;
	always @* begin
		entry_src = {`SRC_W{1'b0}};
		entry_vec = `VEC_SYNC;
		if (take_trap) begin
			entry_src[`SRC_TRAP] = 1'b1;
			entry_vec = `VEC_TRAP;
		end else if (ext_req) begin
			entry_src[`SRC_EXT] = 1'b1;
			entry_vec = `VEC_EXT;
		end else if (tmr_req) begin
			entry_src[`SRC_TIMER] = 1'b1;
			entry_vec = `VEC_TIMER;
		end else if (asy_req) begin
			entry_src[`SRC_ASYNC] = 1'b1;
			entry_vec = `VEC_ASYNC;
		end else begin
			entry_src[`SRC_SYNC] = 1'b1;
			entry_vec = `VEC_SYNC;
		end
	end

	reg [DATA_W-1:0] push_byte;
	always @* begin
		case (idx_q)
			`STK_PCL: push_byte = pc_in[7:0];
			`STK_PCH: push_byte = {{(16-ADDR_W){1'b0}}, pc_in[ADDR_W-1:8]};
			`STK_X: push_byte = x_in;
			`STK_A: push_byte = a_in;
			default: push_byte = {cc_in[7:4], mask_bit, cc_in[2:0]};
		endcase
	end

	// Peripheral enables, option and interrupt enable registers
	always @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			tmr_ctrl_q <= `REG_RESET;
			asy_ctrl_q <= `REG_RESET;
			syn_ctrl_q <= `REG_RESET;
			opt_q <= `OPT_RESET;
			int_en_q <= {`SRC_W{1'b0}};
		end else if (clk_en && reg_wr) begin
			if (hit(reg_addr, `OFF_TIMER_CTRL)) begin
				tmr_ctrl_q <= reg_wdata;
			end else if (hit(reg_addr, `OFF_ASYNC_CTRL2)) begin
				asy_ctrl_q <= reg_wdata;
			end else if (hit(reg_addr, `OFF_SYNC_CTRL)) begin
				syn_ctrl_q <= reg_wdata;
			end else if (hit(reg_addr, `OFF_PIN_OPTION)) begin
				opt_q <= reg_wdata;
			end else if (hit(reg_addr, `OFF_INT_ENABLE)) begin
				int_en_q <= reg_wdata[`SRC_W-1:0];
			end
		end
	end

	// Sticky flags with the two-step clear; a new event wins over the clear
	always @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			tmr_flags_q <= 3'h0;
			asy_flags_q <= 5'h00;
			syn_flags_q <= 2'h0;
			tmr_arm_q <= 3'h0;
			asy_arm_q <= 5'h00;
			syn_arm_q <= 2'h0;
		end else if (clk_en) begin
			tmr_flags_q <= tmr_fn[2:0];
			asy_flags_q <= asy_fn[4:0];
			syn_flags_q <= syn_fn[1:0];
			if (rd_tmr_stat) begin
				tmr_arm_q <= tmr_flags_q;
			end else if (acc_tmr_ctrl) begin
				tmr_arm_q <= 3'h0;
			end
			if (rd_asy_stat) begin
				asy_arm_q <= asy_flags_q;
			end else if (acc_asy_ctrl) begin
				asy_arm_q <= 5'h00;
			end
			if (rd_syn_stat) begin
				syn_arm_q <= syn_flags_q;
			end else if (acc_syn_ctrl) begin
				syn_arm_q <= 2'h0;
			end
		end
	end

	// External pin falling-edge latch, released when its entry is taken
	always @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			irq_prev_q <= 1'b1;
			irq_latch_q <= 1'b0;
		end else if (clk_en) begin
			irq_prev_q <= irq_pin_n;
			if (irq_prev_q & ~irq_pin_n) begin
				irq_latch_q <= 1'b1;
			end else if (ext_taken) begin
				irq_latch_q <= 1'b0;
			end
		end
	end

	// Entry event status, enable gating and interrupt output
	always @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			int_status_q <= {`SRC_W{1'b0}};
			int_out <= 1'b0;
		end else if (clk_en) begin
			int_status_q <= (int_status_q & ~((reg_wr && hit(reg_addr, `OFF_INT_CLEAR)) ?
				reg_wdata[`SRC_W-1:0] : {`SRC_W{1'b0}})) |
				(start_entry ? entry_src : {`SRC_W{1'b0}});
			int_out <= |(int_status_q & int_en_q);
		end
	end

	// Register read port, data valid the cycle after the strobe
	always @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			reg_rdata <= `REG_RESET;
		end else if (clk_en) begin
			if (!reg_rd) begin
				reg_rdata <= `REG_RESET;
			end else if (hit(reg_addr, `OFF_TIMER_CTRL)) begin
				reg_rdata <= tmr_ctrl_q;
			end else if (hit(reg_addr, `OFF_TIMER_FLAGS)) begin
				reg_rdata <= tmr_stat_v;
			end else if (hit(reg_addr, `OFF_ASYNC_CTRL2)) begin
				reg_rdata <= asy_ctrl_q;
			end else if (hit(reg_addr, `OFF_ASYNC_FLAGS)) begin
				reg_rdata <= asy_stat_v;
			end else if (hit(reg_addr, `OFF_SYNC_CTRL)) begin
				reg_rdata <= syn_ctrl_q;
			end else if (hit(reg_addr, `OFF_SYNC_FLAGS)) begin
				reg_rdata <= syn_stat_v;
			end else if (hit(reg_addr, `OFF_PIN_OPTION)) begin
				reg_rdata <= opt_q;
			end else if (hit(reg_addr, `OFF_INT_STATUS)) begin
				reg_rdata <= {{(DATA_W-`SRC_W){1'b0}}, int_status_q};
			end else if (hit(reg_addr, `OFF_INT_ENABLE)) begin
				reg_rdata <= {{(DATA_W-`SRC_W){1'b0}}, int_en_q};
			end else begin
				reg_rdata <= `REG_RESET;
			end
		end
	end

	// Entry, return and reset sequencer
	always @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			state_q <= ST_RESET;
			idx_q <= `STK_PCL;
			vec_q <= `VEC_RESET;
			cpu_hold <= 1'b1;
			mask_bit <= 1'b1;
			stack_push <= 1'b0;
			stack_data <= `REG_RESET;
			stack_pull <= 1'b0;
			pull_sel <= `STK_CC;
			pull_pend_q <= 1'b0;
			pull_sel_q <= `STK_CC;
			restore_valid <= 1'b0;
			restore_sel <= `STK_CC;
			restore_data <= `REG_RESET;
			vector_load <= 1'b0;
			vector_addr <= `VEC_RESET;
		end else if (clk_en) begin
			stack_push <= 1'b0;
			stack_pull <= 1'b0;
			vector_load <= 1'b0;
			restore_valid <= 1'b0;
			pull_pend_q <= stack_pull;
			pull_sel_q <= pull_sel;
			if (pull_pend_q) begin
				restore_valid <= 1'b1;
				restore_sel <= pull_sel_q;
				restore_data <= pull_data;
				if (pull_sel_q == `STK_CC) begin
					mask_bit <= pull_data[`CC_MASK_BIT];
				end
			end else if (mask_set) begin
				mask_bit <= 1'b1;
			end else if (mask_clr) begin
				mask_bit <= 1'b0;
			end
			case (state_q)
				ST_RESET: begin
					vector_load <= 1'b1;
					vector_addr <= `VEC_RESET;
					mask_bit <= 1'b1;
					cpu_hold <= 1'b0;
					state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					if (start_entry) begin
						vec_q <= entry_vec;
						idx_q <= `STK_PCL;
						cpu_hold <= 1'b1;
						state_q <= ST_PUSH;
					end else if (take_rti) begin
						idx_q <= `STK_CC;
						cpu_hold <= 1'b1;
						state_q <= ST_PULL;
					end
				end
				ST_PUSH: begin
					stack_push <= 1'b1;
					stack_data <= push_byte;
					if (idx_q == `STK_CC) begin
						mask_bit <= 1'b1;
						state_q <= ST_VEC;
					end else begin
						idx_q <= idx_q + 3'h1;
					end
				end
				ST_VEC: begin
					vector_load <= 1'b1;
					vector_addr <= vec_q;
					cpu_hold <= 1'b0;
					state_q <= ST_IDLE;
				end
				ST_PULL: begin
					stack_pull <= 1'b1;
					pull_sel <= idx_q;
					if (idx_q == `STK_PCL) begin
						state_q <= ST_IDLE;
					end else begin
						idx_q <= idx_q - 3'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
			if (state_q == ST_IDLE && pull_pend_q && pull_sel_q == `STK_PCL) begin
				cpu_hold <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ---- dv/mcu_intv_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcu_intv_defs.vh"
module mcu_intv_checker (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic instr_boundary,
	input wire logic trap_exec,
	input wire logic rti_exec,
	input wire logic [12:0] pc_in,
	input wire logic [7:0] x_in,
	input wire logic [7:0] a_in,
	input wire logic [7:0] cc_in,
	input wire logic cpu_hold,
	input wire logic mask_bit,
	input wire logic stack_push,
	input wire logic [7:0] stack_data,
	input wire logic stack_pull,
	input wire logic [2:0] pull_sel,
	input wire logic restore_valid,
	input wire logic [2:0] restore_sel,
	input wire logic [7:0] restore_data,
	input wire logic vector_load,
	input wire logic [12:0] vector_addr
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_idle;
		!cpu_hold && !vector_load && !$past(cpu_hold);
	endsequence
	sequence s_push;
		##2 stack_push && stack_data == pc_in[7:0]
		##1 stack_push && stack_data == {3'h0, pc_in[12:8]}
		##1 stack_push && stack_data == x_in
		##1 stack_push && stack_data == a_in
		##1 stack_push && {stack_data[7:4], stack_data[2:0]} == {cc_in[7:4], cc_in[2:0]};
	endsequence
	sequence s_pull;
		stack_pull && pull_sel == `STK_CC ##1 stack_pull && pull_sel == `STK_A
		##1 stack_pull && pull_sel == `STK_X ##1 stack_pull && pull_sel == `STK_PCH
		##1 stack_pull && pull_sel == `STK_PCL;
	endsequence
	AST_TRAP_STACK: assert property (trap_exec ##0 s_idle |-> s_push)
		else $error("stacking order wrong");
	AST_TRAP_VECTOR: assert property (trap_exec ##0 s_idle |-> ##6 mask_bit
		##1 vector_load && vector_addr == `VEC_TRAP && !cpu_hold)
		else $error("trap vector wrong");
	AST_HOLD_CAUSE: assert property ($rose(cpu_hold) |->
		$past(trap_exec || instr_boundary || rti_exec))
		else $error("entry outside an instruction boundary");
	AST_MASKED_BOUNDARY: assert property (instr_boundary && mask_bit && !trap_exec
		&& !rti_exec ##0 s_idle |=> !cpu_hold)
		else $error("entry while masked");
	AST_RTI_PULL: assert property (rti_exec && !trap_exec ##0 s_idle
		|-> ##2 s_pull ##2 !cpu_hold)
		else $error("return pull order wrong");
	AST_RTI_MASK: assert property (restore_valid && restore_sel == `STK_CC
		|=> mask_bit == $past(restore_data[`CC_MASK_BIT]))
		else $error("mask not restored");
	AST_RESET_VECTOR: assert property ($rose(rst_n) |->
		##[1:4] vector_load && vector_addr == `VEC_RESET && mask_bit)
		else $error("reset vector missing");
	AST_ENTRY_MASK: assert property (instr_boundary && !mask_bit && !trap_exec
		&& !rti_exec ##0 s_idle ##1 cpu_hold |-> ##5 mask_bit ##1 vector_load)
		else $error("entry did not set mask");
endmodule
`default_nettype wire

// ---- dv/cpu_stack_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_model (
	input wire logic core_clk,
	input wire logic stack_push,
	input wire logic [7:0] stack_data,
	input wire logic stack_pull,
	input wire logic [2:0] pull_sel,
	output logic [7:0] pull_data
);
	logic [7:0] mem [0:4];
	logic [2:0] idx = 3'h0;
	initial pull_data = 8'h00;
	always @(posedge core_clk) begin
		if (stack_push) begin
			mem[idx] <= stack_data;
			idx <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
		end
		// Released bus inverts its previous value every cycle
		pull_data <= stack_pull ? mem[pull_sel] : ~pull_data;
	end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcu_intv_defs.vh"
module tb_top;
	logic core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic irq_pin_n = 1'h1, instr_boundary = 1'h0, trap_exec = 1'h0, rti_exec = 1'h0;
	logic mask_set = 1'h0, mask_clr = 1'h0;
	logic [12:0] reg_addr = 13'h0000, pc_in = 13'h1ABC, vector_addr;
	logic [7:0] reg_wdata = 8'h00, x_in = 8'h5A, a_in = 8'hC3, cc_in = 8'h05;
	logic [7:0] reg_rdata, pull_data, stack_data, restore_data, rd_v;
	logic [9:0] ev = 10'h000;
	logic [2:0] pull_sel, restore_sel;
	logic cpu_hold, mask_bit, stack_push, stack_pull, restore_valid, vector_load, int_out;
	logic [7:0] stk [5] = '{8'hBC, 8'h1A, 8'h5A, 8'hC3, 8'h05};
	logic [12:0] regs [6] = '{`OFF_TIMER_CTRL, `OFF_ASYNC_CTRL2, `OFF_SYNC_CTRL,
		`OFF_PIN_OPTION, `OFF_INT_ENABLE, 13'h0100};
	int fail_count = 0, checks_done = 0, cyc = 0;
	mcu_interrupt_vectoring i_dut (.*, .capture_evt(ev[9]), .compare_evt(ev[8]),
		.overflow_evt(ev[7]), .tx_empty_evt(ev[6]), .tx_done_evt(ev[5]), .rx_full_evt(ev[4]),
		.idle_evt(ev[3]), .overrun_evt(ev[2]), .sync_done_evt(ev[1]), .sync_fault_evt(ev[0]));
	cpu_stack_model i_cpu (.*);
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task tally_and_finish; begin
		$display("checks %0d failures %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	end endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task chk(input string nm, input logic [12:0] got, input logic [12:0] exp); begin
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
		end
	end endtask
	task wr_reg(input logic [12:0] a, input logic [7:0] d); begin
		@(posedge core_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1; end
		@(posedge core_clk) reg_wr <= 1'h0;
	end endtask
	task rd_reg(input logic [12:0] a, output logic [7:0] d); begin
		@(posedge core_clk) begin reg_addr <= a; reg_rd <= 1'h1; end
		@(posedge core_clk) reg_rd <= 1'h0;
		#1 d = reg_rdata;
	end endtask
	task ev_p(input logic [9:0] m); begin
		@(posedge core_clk) ev <= m;
		@(posedge core_clk) ev <= 10'h000;
	end endtask
	task mpulse(input logic s); begin
		@(posedge core_clk) begin mask_set <= s; mask_clr <= !s; end
		@(posedge core_clk) begin mask_set <= 1'h0; mask_clr <= 1'h0; end
	end endtask
	task enter(input logic t, input logic [12:0] v);
		int n;
		begin
			@(posedge core_clk) begin instr_boundary <= !t; trap_exec <= t; end
			@(posedge core_clk) begin instr_boundary <= 1'h0; trap_exec <= 1'h0; end
			n = 0;
			while (vector_load !== 1'h1 && n < 20) begin
				@(posedge core_clk);
				#1 n++;
			end
			chk("vector", vector_addr, v);
		end
	endtask
	task quiet; begin
		@(posedge core_clk) instr_boundary <= 1'h1;
		@(posedge core_clk) instr_boundary <= 1'h0;
		repeat (3) @(posedge core_clk);
		#1 chk("hold", cpu_hold, 1'h0);
	end endtask
	task ret(input logic m); begin
		@(posedge core_clk) rti_exec <= 1'h1;
		@(posedge core_clk) rti_exec <= 1'h0;
		repeat (8) @(posedge core_clk);
		#1 chk("mask after return", mask_bit, m);
	end endtask
	task io_chk(input logic e); begin
		repeat (2) @(posedge core_clk);
		#1 chk("int_out", int_out, e);
	end endtask
	task t_reset; begin
		chk("mask at reset", mask_bit, 1'h1);
		for (int i = 0; i < 6; i++) begin
			rd_reg(regs[i], rd_v);
			chk("reset value", rd_v, 8'h00);
		end
	end endtask
	task t_timer; begin
		ev_p(10'h380);
		rd_reg(`OFF_TIMER_FLAGS, rd_v);
		chk("timer flags", rd_v, 8'hE0);
		mpulse(1'h0);
		quiet;
		rd_reg(`OFF_TIMER_CTRL, rd_v);
		wr_reg(`OFF_TIMER_FLAGS, 8'hFF);
		rd_reg(`OFF_TIMER_FLAGS, rd_v);
		chk("flags cleared", rd_v, 8'h00);
		wr_reg(`OFF_TIMER_CTRL, 8'hE0);
	end endtask
	task t_priority; begin
		wr_reg(`OFF_ASYNC_CTRL2, 8'h20);
		wr_reg(`OFF_SYNC_CTRL, 8'h80);
		ev_p(10'h212);
		rd_reg(`OFF_ASYNC_FLAGS, rd_v);
		chk("async flags", rd_v, 8'h20);
		@(posedge core_clk) irq_pin_n <= 1'h0;
		mpulse(1'h1);
		quiet;
		mpulse(1'h0);
		enter(1'h0, `VEC_EXT);
		@(posedge core_clk) irq_pin_n <= 1'h1;
		mpulse(1'h0);
		enter(1'h0, `VEC_TIMER);
		wr_reg(`OFF_TIMER_CTRL, 8'h00);
		mpulse(1'h0);
		enter(1'h0, `VEC_ASYNC);
		wr_reg(`OFF_ASYNC_CTRL2, 8'h00);
		mpulse(1'h0);
		enter(1'h0, `VEC_SYNC);
		wr_reg(`OFF_SYNC_CTRL, 8'h00);
	end endtask
	task t_trap; begin
		mpulse(1'h0);
		enter(1'h1, `VEC_TRAP);
		for (int i = 0; i < 5; i++) chk("stack byte", i_cpu.mem[i], stk[i]);
		ret(1'h0);
		mpulse(1'h1);
		enter(1'h1, `VEC_TRAP);
		chk("stacked cc", i_cpu.mem[4], 8'h0D);
		ret(1'h1);
	end endtask
	task t_pin_mode; begin
		wr_reg(`OFF_PIN_OPTION, 8'h02);
		@(posedge core_clk) irq_pin_n <= 1'h0;
		mpulse(1'h0);
		enter(1'h0, `VEC_EXT);
		mpulse(1'h0);
		quiet;
		wr_reg(`OFF_PIN_OPTION, 8'h00);
		mpulse(1'h0);
		enter(1'h0, `VEC_EXT);
		@(posedge core_clk) irq_pin_n <= 1'h1;
	end endtask
	task t_int_out; begin
		rd_reg(`OFF_INT_STATUS, rd_v);
		chk("int status", rd_v, 8'h1F);
		wr_reg(`OFF_INT_ENABLE, 8'h01);
		io_chk(1'h1);
		wr_reg(`OFF_INT_ENABLE, 8'h00);
		io_chk(1'h0);
		wr_reg(`OFF_INT_ENABLE, 8'h01);
		wr_reg(`OFF_INT_CLEAR, 8'h1F);
		io_chk(1'h0);
	end endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge core_clk);
		t_reset;
		t_timer;
		t_priority;
		t_trap;
		t_pin_mode;
		t_int_out;
		tally_and_finish();
	end
endmodule
bind mcu_interrupt_vectoring mcu_intv_checker i_chk (.core_clk, .rst_n, .instr_boundary,
	.trap_exec, .rti_exec, .pc_in, .x_in, .a_in, .cc_in, .cpu_hold, .mask_bit, .stack_push,
	.stack_data, .stack_pull, .pull_sel, .restore_valid, .restore_sel, .restore_data,
	.vector_load, .vector_addr);
`default_nettype wire
